/* File: rtl/gcp_command_port.v */
// five-pin command-driven io port: command decode, sampling, edges, reply
//
// Contract
// - five user io pins, each shared with a default function.
// - output mode can drive a 100 Hz pwm with programmable duty.
// - sample all pins at 32 Hz independent of queries; keep latest level.
// - latch rising and falling edges per pin since last query of it.
// - level 0 low, 1..99 duty percent, 100 high, 101..255 invalid.
// - three-bit drive mode selects pull/drive strength for one and zero.
// - function bit zero gives default role, one gives user control.
// - set command answered by ack type 0x62 with no data.
// - read command 0x23 with one index; indices 5..255 reserved.
// - reported level is sampled state; sub-interval pulses may be missed.
// - read returns stored requested level 0..100.
// - read returns function bit and drive mode, upper bits zero.
// - pin config captured on store-boot-state and restored at power-up.
// - defaults: 1 power sense, 2 power control, 3 reset, 4 one-wire.
// - drive mode 010 with function clear uses pin as default-role input.
`timescale 1ns/1ps
`include "gcp_regs.vh"
module gcp_command_port
#(
  parameter NUM_PINS = `GCP_NUM_PINS,
  parameter SAMPLE_CYC = `GCP_SAMPLE_CYC,
  parameter PWM_STEP_CYC = `GCP_PWM_STEP_CYC
)
(
  input wire clock,
  input wire rstn,
  input wire cmdValid,
  input wire [7:0] cmdType,
  input wire [1:0] cmdLen,
  input wire [7:0] cmdData0,
  input wire [7:0] cmdData1,
  input wire [7:0] cmdData2,
  input wire storeBoot,
  input wire [NUM_PINS-1:0] pinIn,
  input wire [NUM_PINS-1:0] defOut,
  input wire [NUM_PINS-1:0] defOe,
  output reg rspValid,
  output reg [7:0] rspType,
  output reg [2:0] rspLen,
  output reg [7:0] rspData0,
  output reg [7:0] rspData1,
  output reg [7:0] rspData2,
  output reg [7:0] rspData3,
  output reg cmdError,
  output wire [NUM_PINS-1:0] defRoleIn,
  output wire [NUM_PINS-1:0] pinOut,
  output wire [NUM_PINS-1:0] pinOe,
  output wire [NUM_PINS-1:0] pinPullUp,
  output wire [NUM_PINS-1:0] pinPullDown,
  output wire [NUM_PINS-1:0] pinSlow
);
  reg [31:0] sampleCnt_q;
  reg [31:0] stepCnt_q;
  reg [6:0] phase_q;
  reg [NUM_PINS-1:0] level_q;
  reg [NUM_PINS-1:0] rise_q;
  reg [NUM_PINS-1:0] fall_q;
  reg [7:0] outLvl_q [0:NUM_PINS-1];
  reg [3:0] cfg_q [0:NUM_PINS-1];
  reg [7:0] bootLvl_q [0:NUM_PINS-1];
  reg [3:0] bootCfg_q [0:NUM_PINS-1];
  reg primed_q;
  reg restore_q;
  wire sampleTick;
  wire idxOk;
  wire lvlOk;
  wire cfgOk;
  wire isSet;
  wire isRead;
  wire setOk;
  wire [2:0] idx;
  integer i;
  integer j;

  ////////////////////////////////////////////////////////////////////////////
  // timebases
  assign sampleTick = (sampleCnt_q == SAMPLE_CYC - 1);
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sampleCnt_q <= 32'h0;
      stepCnt_q <= 32'h0;
      phase_q <= 7'h0;
    end
    else
    begin
      sampleCnt_q <= sampleTick ? 32'h0 : sampleCnt_q + 32'h1;
      if (stepCnt_q == PWM_STEP_CYC - 1)
      begin
        stepCnt_q <= 32'h0;
        // 100 steps per period gives the 100 Hz frame
        phase_q <= (phase_q == 7'd99) ? 7'h0 : phase_q + 7'h1;
      end
      else
        stepCnt_q <= stepCnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  assign idx = cmdData0[2:0];
  assign idxOk = (cmdData0 < NUM_PINS);
  assign lvlOk = (cmdData1 <= `GCP_LVL_HIGH);
  // a reserved mode is refused rather than trusted
  assign cfgOk = (cmdLen < 2'd3) ||
    ((cmdData2[7:4] == 4'h0) && (cmdData2[2:0] != `GCP_DM_RESERVED));
  assign isSet = cmdValid && (cmdType == `GCP_CMD_SET);
  assign isRead = cmdValid && (cmdType == `GCP_CMD_READ) && (cmdLen == 2'd1);
  assign setOk = isSet && (cmdLen >= 2'd2) && idxOk && lvlOk && cfgOk;

  ////////////////////////////////////////////////////////////////////////////
  // sampling, edge capture and pin configuration
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      level_q <= {NUM_PINS{1'b0}};
      rise_q <= {NUM_PINS{1'b0}};
      fall_q <= {NUM_PINS{1'b0}};
      primed_q <= 1'b0;
      restore_q <= 1'b1;
      for (i = 0; i < NUM_PINS; i = i + 1)
      begin
        outLvl_q[i] <= `GCP_BOOT_LVL;
        cfg_q[i] <= `GCP_BOOT_CFG;
      end
    end
    else
    begin
      restore_q <= 1'b0;
      // first sample only seeds the level: a pulled-up pin would show a false rise
      if (sampleTick)
        primed_q <= 1'b1;
      for (i = 0; i < NUM_PINS; i = i + 1)
      begin
        // query clears only the queried pin; a new edge in that cycle wins
        if (isRead && idxOk && (idx == i))
        begin
          rise_q[i] <= 1'b0;
          fall_q[i] <= 1'b0;
        end
        if (sampleTick)
        begin
          level_q[i] <= pinIn[i];
          if (primed_q && pinIn[i] && !level_q[i])
            rise_q[i] <= 1'b1;
          if (primed_q && !pinIn[i] && level_q[i])
            fall_q[i] <= 1'b1;
        end
        // boot copy first, so a set taken in the same cycle still wins
        if (restore_q)
        begin
          outLvl_q[i] <= bootLvl_q[i];
          cfg_q[i] <= bootCfg_q[i];
        end
        if (setOk && (idx == i))
        begin
          outLvl_q[i] <= cmdData1;
          if (cmdLen == 2'd3)
            cfg_q[i] <= cmdData2[3:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot copy has no reset so it outlives rstn, as a stored boot state must;
  // it is unknown until the first store, so store once while reset is held
  always @(posedge clock)
  begin
    for (j = 0; j < NUM_PINS; j = j + 1)
    begin
      if (storeBoot)
      begin
        bootLvl_q[j] <= outLvl_q[j];
        bootCfg_q[j] <= cfg_q[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // responses
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rspValid <= 1'b0;
      rspType <= 8'h00;
      rspLen <= 3'h0;
      rspData0 <= 8'h00;
      rspData1 <= 8'h00;
      rspData2 <= 8'h00;
      rspData3 <= 8'h00;
      cmdError <= 1'b0;
    end
    else
    begin
      rspValid <= 1'b0;
      cmdError <= 1'b0;
      if (setOk)
      begin
        rspValid <= 1'b1;
        rspType <= `GCP_ACK_SET;
        rspLen <= 3'h0;
      end
      else if (isRead && idxOk)
      begin
        rspValid <= 1'b1;
        rspType <= `GCP_ACK_READ;
        rspLen <= 3'h4;
        rspData0 <= cmdData0;
        rspData1 <= {5'h00, fall_q[idx], rise_q[idx], level_q[idx]};
        rspData2 <= outLvl_q[idx];
        rspData3 <= {4'h0, cfg_q[idx]};
      end
      else if (isSet || (cmdValid && (cmdType == `GCP_CMD_READ)))
        cmdError <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin drivers
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : pins
      assign defRoleIn[g] = !cfg_q[g][`GCP_CFG_FUNC_BIT] &&
        (cfg_q[g][2:0] == `GCP_DM_HIZ);
      gcp_pin_drive u_drive
      (
        .clock(clock),
        .rstn(rstn),
        .phase(phase_q),
        .level(outLvl_q[g]),
        .driveMode(cfg_q[g][2:0]),
        .userOwned(cfg_q[g][`GCP_CFG_FUNC_BIT]),
        .defOut(defOut[g]),
        .defOe(defOe[g]),
        .pinOut(pinOut[g]),
        .pinOe(pinOe[g]),
        .pinPullUp(pinPullUp[g]),
        .pinPullDown(pinPullDown[g]),
        .pinSlow(pinSlow[g])
      );
    end
  endgenerate
endmodule

/* File: shared/gcp_regs.vh */
// constants for the command-driven five-pin io port
`ifndef GCP_REGS_VH
`define GCP_REGS_VH
`define GCP_CMD_SET 8'h22
`define GCP_CMD_READ 8'h23
`define GCP_ACK_SET 8'h62
`define GCP_ACK_READ 8'h63
`define GCP_NUM_PINS 5
`define GCP_LVL_HIGH 8'h64
`define GCP_DM_STRONG_UP_RES_DN 3'h0
`define GCP_DM_STRONG_BOTH 3'h1
`define GCP_DM_HIZ 3'h2
`define GCP_DM_RES_UP_STRONG_DN 3'h3
`define GCP_DM_SLOW_UP_HIZ 3'h4
`define GCP_DM_SLOW_BOTH 3'h5
`define GCP_DM_RESERVED 3'h6
`define GCP_DM_HIZ_SLOW_DN 3'h7
`define GCP_CFG_FUNC_BIT 3
`define GCP_CLK_HZ 40000000
`define GCP_PWM_HZ 100
`define GCP_SAMPLE_HZ 32
`define GCP_PWM_STEP_CYC (`GCP_CLK_HZ / (`GCP_PWM_HZ * 100))
`define GCP_SAMPLE_CYC (`GCP_CLK_HZ / `GCP_SAMPLE_HZ)
`define GCP_BOOT_CFG 4'h2
`define GCP_BOOT_LVL 8'h00
`endif

/* File: rtl/gcp_pin_drive.v */
// one pin: pwm generator and drive-mode decode
`timescale 1ns/1ps
`include "gcp_regs.vh"
module gcp_pin_drive
(
  input wire clock,
  input wire rstn,
  input wire [6:0] phase,
  input wire [7:0] level,
  input wire [2:0] driveMode,
  input wire userOwned,
  input wire defOut,
  input wire defOe,
  output reg pinOut,
  output reg pinOe,
  output reg pinPullUp,
  output reg pinPullDown,
  output reg pinSlow
);
  wire pwmBit;
  reg [2:0] dm;
  reg bitVal;
  // 0 low, 1..99 duty, 100 high: compare works for all three
  assign pwmBit = ({1'b0, phase} < level);
  always @*
  begin
    dm = driveMode;
    bitVal = userOwned ? pwmBit : defOut;
    if (!userOwned && !defOe)
      dm = `GCP_DM_HIZ;
  end
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
      pinPullUp <= 1'b0;
      pinPullDown <= 1'b0;
      pinSlow <= 1'b0;
    end
    else
    begin
      pinOut <= bitVal;
      pinPullUp <= 1'b0;
      pinPullDown <= 1'b0;
      pinSlow <= 1'b0;
      pinOe <= 1'b0;
      case (dm)
        `GCP_DM_STRONG_UP_RES_DN:
        begin
          pinOe <= bitVal;
          pinPullDown <= !bitVal;
        end
        `GCP_DM_STRONG_BOTH:
          pinOe <= 1'b1;
        `GCP_DM_RES_UP_STRONG_DN:
        begin
          pinOe <= !bitVal;
          pinPullUp <= bitVal;
        end
        `GCP_DM_SLOW_UP_HIZ:
        begin
          pinOe <= bitVal;
          pinSlow <= 1'b1;
        end
        `GCP_DM_SLOW_BOTH:
        begin
          pinOe <= 1'b1;
          pinSlow <= 1'b1;
        end
        `GCP_DM_HIZ_SLOW_DN:
        begin
          pinOe <= !bitVal;
          pinSlow <= 1'b1;
        end
        default:
          pinOe <= 1'b0;
      endcase
    end
  end
endmodule

/* File: tb/gcp_pin_load.sv */
// pin load model: outside level seen through the port's drive and pulls
`timescale 1ns/1ps
module gcp_pin_load
(
  input wire [4:0] pinOut,
  input wire [4:0] pinOe,
  input wire [4:0] pinPullUp,
  input wire [4:0] pinPullDown,
  input wire [4:0] extLevel,
  output wire [4:0] pinIn
);
  // a driven pin beats its pulls, pulls beat the outside level
  assign pinIn = (pinOe & pinOut) | (~pinOe & (pinPullUp | (~pinPullDown & extLevel)));
endmodule

/* File: tb/gcp_command_port_monitor.sv */
// port-level assertions for the command-driven io port
`timescale 1ns/1ps
module gcp_command_port_monitor
#(
  parameter NUM_PINS = 5
)
(
  input wire clock,
  input wire rstn,
  input wire cmdValid,
  input wire [7:0] cmdType,
  input wire [1:0] cmdLen,
  input wire [7:0] cmdData0,
  input wire [7:0] cmdData1,
  input wire [7:0] cmdData2,
  input wire rspValid,
  input wire [7:0] rspType,
  input wire [2:0] rspLen,
  input wire [7:0] rspData1,
  input wire [7:0] rspData2,
  input wire [7:0] rspData3,
  input wire cmdError,
  input wire [NUM_PINS-1:0] pinPullUp,
  input wire [NUM_PINS-1:0] pinPullDown
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  wire isSet = cmdValid && cmdType == 8'h22;
  wire isRd = cmdValid && cmdType == 8'h23;
  wire okSet = isSet && cmdLen[1] && cmdData0 < 8'h05 && cmdData1 < 8'h65 &&
    (!cmdLen[0] || (cmdData2[7:4] == 4'h0 && cmdData2[2:0] != 3'h6));
  wire isRpl = rspValid && rspType == 8'h63;
  ////////////////////////////////////////////////////////////////////////////
  a_set_ack: assert property (okSet |=> rspValid && rspType == 8'h62 && rspLen == 3'h0)
    else $error("set not acknowledged");
  a_set_refuse: assert property (isSet && !okSet |=> cmdError && !rspValid)
    else $error("bad set not refused");
  a_read_reply: assert property (isRd && cmdLen == 2'h1 && cmdData0 < 8'h05
    |=> rspValid && rspType == 8'h63 && rspLen == 3'h4)
    else $error("read reply wrong");
  a_read_refuse: assert property (isRd && cmdData0 > 8'h04 |=> cmdError && !rspValid)
    else $error("reserved index not refused");
  a_level_range: assert property (isRpl |-> rspData2 <= 8'h64)
    else $error("reported level out of range");
  a_upper_zero: assert property (isRpl |-> rspData3[7:4] == 4'h0 && rspData1[7:3] == 5'h0)
    else $error("reserved reply bits set");
  a_other_quiet: assert property (cmdValid && !isSet && !isRd |=> !rspValid && !cmdError)
    else $error("unknown type answered");
  a_pull_excl: assert property ((pinPullUp & pinPullDown) == '0)
    else $error("pull up and down together");
endmodule
bind gcp_command_port gcp_command_port_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.clock(clock),
  .rstn(rstn), .cmdValid(cmdValid), .cmdType(cmdType), .cmdLen(cmdLen), .cmdData0(cmdData0),
  .cmdData1(cmdData1), .cmdData2(cmdData2), .rspValid(rspValid), .rspType(rspType),
  .rspLen(rspLen), .rspData1(rspData1), .rspData2(rspData2), .rspData3(rspData3),
  .cmdError(cmdError), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown));

/* File: tb/gcp_command_port_bench.sv */
// self-checking bench for the command-driven io port
`timescale 1ns/1ps
module gcp_command_port_bench;
  typedef struct packed {logic [7:0] t; logic [1:0] n; logic [7:0] a, b, c; logic e;
    logic [7:0] l, f;} gcp_row_t;
  // storeBoot high during reset loads the boot copy, which has no reset
  logic clock = 0, rstn = 0, cmdValid = 0, storeBoot = 1;
  logic [4:0] defOut = 0, defOe = 0;
  logic [7:0] cmdType = 0, cmdData0 = 0, cmdData1 = 0, cmdData2 = 0;
  logic [1:0] cmdLen = 0;
  logic [4:0] extLevel = 0;
  wire [4:0] pinIn, pinOut, pinOe, pinPullUp, pinPullDown, pinSlow, defRoleIn;
  wire rspValid, cmdError;
  wire [7:0] rspType, rspData0, rspData1, rspData2, rspData3;
  wire [2:0] rspLen;
  int n_mismatch = 0, compares = 0, hi;
  gcp_row_t r;
  // per drive mode {oe, up, down, slow}: output one, output zero
  logic [31:0] hiTab = 32'h00994088, loTab = 32'h90908082;
  gcp_row_t rows[15] = '{'{8'h23, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h02},
    '{8'h22, 2'h3, 8'h01, 8'h32, 8'h09, 1'b0, 8'h00, 8'h00},
    '{8'h23, 2'h1, 8'h01, 8'h00, 8'h00, 1'b0, 8'h32, 8'h09},
    '{8'h22, 2'h3, 8'h01, 8'h65, 8'h09, 1'b1, 8'h00, 8'h00},
    '{8'h22, 2'h3, 8'h01, 8'h14, 8'h19, 1'b1, 8'h00, 8'h00},
    '{8'h22, 2'h3, 8'h05, 8'h14, 8'h09, 1'b1, 8'h00, 8'h00},
    '{8'h22, 2'h1, 8'h01, 8'h14, 8'h09, 1'b1, 8'h00, 8'h00},
    '{8'h23, 2'h1, 8'h01, 8'h00, 8'h00, 1'b0, 8'h32, 8'h09},
    '{8'h22, 2'h2, 8'h01, 8'h1e, 8'h00, 1'b0, 8'h00, 8'h00},
    '{8'h23, 2'h1, 8'h01, 8'h00, 8'h00, 1'b0, 8'h1e, 8'h09},
    '{8'h23, 2'h1, 8'h05, 8'h00, 8'h00, 1'b1, 8'h00, 8'h00},
    '{8'h21, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00},
    '{8'h22, 2'h3, 8'h04, 8'h64, 8'h0f, 1'b0, 8'h00, 8'h00},
    '{8'h23, 2'h1, 8'h04, 8'h00, 8'h00, 1'b0, 8'h64, 8'h0f},
    '{8'h23, 2'h2, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 8'h00}};
  always #12.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  gcp_command_port #(.SAMPLE_CYC(8), .PWM_STEP_CYC(2)) u_gcp_command_port (.clock(clock),
    .rstn(rstn), .cmdValid(cmdValid), .cmdType(cmdType), .cmdLen(cmdLen), .cmdData0(cmdData0),
    .cmdData1(cmdData1), .cmdData2(cmdData2), .storeBoot(storeBoot), .pinIn(pinIn),
    .defOut(defOut), .defOe(defOe), .rspValid(rspValid), .rspType(rspType), .rspLen(rspLen),
    .rspData0(rspData0), .rspData1(rspData1), .rspData2(rspData2), .rspData3(rspData3),
    .cmdError(cmdError), .defRoleIn(defRoleIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullUp(pinPullUp),
    .pinPullDown(pinPullDown), .pinSlow(pinSlow));
  gcp_pin_load u_gcp_pin_load (.pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp),
    .pinPullDown(pinPullDown), .extLevel(extLevel), .pinIn(pinIn));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  task cmd(input gcp_row_t q);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdType <= q.t;
    cmdLen <= q.n;
    cmdData0 <= q.a;
    cmdData1 <= q.b;
    cmdData2 <= q.c;
    @(posedge clock);
    cmdValid <= 1'b0;
    #1;
    chk({cmdError, rspValid}, {q.e, !q.e && q.t != 8'h21});
    if (!q.e && q.t != 8'h21)
      chk({rspType, rspLen}, {q.t | 8'h40, q.t == 8'h23 ? 3'h4 : 3'h0});
    if (!q.e && q.t == 8'h23)
      chk({rspData0, rspData2, rspData3}, {q.a, q.l, q.f});
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    storeBoot <= 1'b0;
    for (int i = 0; i < 15; i++)
      cmd(rows[i]);
    chk(defRoleIn, 5'h0d);
    $display("command table done");
    r = rows[0];
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock);
      extLevel <= {4'h0, k == 0};
      // several sample periods so the new level is surely seen
      repeat (20) @(posedge clock);
      cmd(r);
      chk(rspData1[2:0], k == 0 ? 3'h3 : (k == 1 ? 3'h4 : 3'h0));
      if (k == 0)
        cmd(r);
      if (k == 0)
        chk(rspData1[2:0], 3'h1);
    end
    $display("sampling done");
    for (int m = 0; m < 16; m++)
    begin
      r = '{8'h22, 2'h3, 8'h03, m[0] ? 8'h64 : 8'h00, 8'h08 | m[3:1], m[3:1] == 3'h6, 0, 0};
      cmd(r);
      @(posedge clock);
      #1;
      hi = m[0] ? hiTab[4*m[3:1] +: 4] : loTab[4*m[3:1] +: 4];
      if (m[3:1] != 3'h6)
        chk({pinOe[3], pinPullUp[3], pinPullDown[3], pinSlow[3] & pinOe[3], pinOut[3] & pinOe[3]},
          {hi[3:0], hi[3] & m[0]});
    end
    $display("drive modes done");
    cmd('{8'h22, 2'h3, 8'h00, 8'h19, 8'h09, 1'b0, 8'h00, 8'h00});
    @(posedge clock);
    hi = 0;
    // one whole pwm period of 100 steps of 2 cycles
    repeat (200)
    begin
      @(posedge clock);
      #1;
      hi += (pinOut[0] & pinOe[0]);
    end
    chk(hi, 24'h32);
    $display("pwm done");
    // pin 2 left to its default role with strong drive both ways
    cmd('{8'h22, 2'h3, 8'h02, 8'h00, 8'h01, 1'b0, 8'h00, 8'h00});
    @(posedge clock);
    defOe <= 5'h04;
    defOut <= 5'h04;
    repeat (2) @(posedge clock);
    #1;
    chk({pinOe[2], pinOut[2], defRoleIn[2]}, 3'h6);
    @(posedge clock);
    defOe <= 5'h00;
    repeat (2) @(posedge clock);
    #1;
    chk(pinOe[2], 1'b0);
    $display("default role done");
    @(posedge clock);
    storeBoot <= 1'b1;
    @(posedge clock);
    storeBoot <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk(pinOe, 5'h00);
    // pin 0 comes back as stored, not as the reset default
    cmd('{8'h23, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 8'h19, 8'h09});
    chk(pinOe, 5'h03);
    $display("reset done");
    end_sim;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    end_sim;
  end
endmodule
